//--- verilog/lbhcs_pkg.sv
// constants, states and carriers for the local bus hold and chip select block
// Function
// - The bus request input may change at any time and is synchronized before the grant logic uses it.
// - The grant is raised only at the end of a final bus state or an idle state, never inside a cycle.
// - In the cycle the grant rises, the address/data bus and the bus controls are floated.
// - The other master holds its request for as long as it needs the bus, and the grant falls once the request is seen low.
// - After the grant falls, the bus and controls are driven again when the next own bus cycle starts.
// - The upper memory select goes low for memory references inside the programmed upper block.
// - The lower memory select goes low for memory references inside the programmed lower block.
// - Four mid-range selects each go low for memory references inside their part of the programmed mid-range region.
// - Five peripheral selects each go low for references to their programmed part of the peripheral area.
// - All memory and peripheral selects stay driven while another master holds the bus.
// - Two more pins act either as the sixth and seventh peripheral selects or as latched address bits 1 and 2.
// - In latched address mode those two pins keep the last latched value through a hold and never float.
// - The transceiver direction is low for data into the device and high while write data is driven.
// - The transceiver enable is low during each memory and I/O access and high whenever the direction changes.
// - After reset the transceiver enable is driven high for one clock and then floated, and it floats during a hold.
package lbhcs_pkg;

  localparam int          ADDR_W       = 20;
  localparam int          DATA_W       = 8;
  localparam int          KB_LSB       = 10; // 1K block granularity
  localparam int          MID_LSB      = 13; // 8K region granularity
  localparam int          MID_W        = ADDR_W - MID_LSB;
  localparam logic [4:0]  MID_IDX_BASE = 5'h0B; // quarter index sits at 11 + size code
  localparam int          PIDX_MSB     = 9;
  localparam int          PIDX_LSB     = 7; // 128-byte peripheral blocks
  localparam int          N_MID        = 4;
  localparam int          N_PERIPH     = 7;
  localparam int          SYNC_STAGES  = 2;
  localparam int          LAT_A1_BIT   = 1;
  localparam int          LAT_A2_BIT   = 2;
  localparam logic        XCVR_EN_RST  = 1'b1;

  // bus state sequencer
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000, // idle bus state
    ST_T1    = 3'b001,
    ST_T2    = 3'b010,
    ST_T3    = 3'b011,
    ST_T4    = 3'b100, // final bus state
    ST_HOLD  = 3'b101
  } lbhcs_state_t;

  // one bus cycle request from the core
  typedef struct packed {
    logic              is_mem;
    logic              is_write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } lbhcs_req_t;

  // range programming, held by the core's own control logic
  typedef struct packed {
    logic [ADDR_W-KB_LSB-1:0] upper_base;   // first 1K block of the upper region
    logic [ADDR_W-KB_LSB-1:0] lower_top;    // first 1K block above the lower region
    logic [MID_W-1:0]         mid_base;     // 8K-aligned mid-range base
    logic [2:0]               mid_size_log; // region is 8K shifted left by this
    logic [ADDR_W-KB_LSB-1:0] periph_base;  // 1K block of the peripheral area
    logic                     periph_in_io; // peripheral area in I/O space
    logic                     latch_addr_mode;
  } lbhcs_cfg_t;

  // active-high select decode
  typedef struct packed {
    logic                upper;
    logic                lower;
    logic [N_MID-1:0]    mid;
    logic [N_PERIPH-1:0] periph;
  } lbhcs_sel_t;

endpackage

//--- verilog/lbhcs_sync.sv
// multi-stage level synchronizer for an asynchronous input
`timescale 1ns/100ps
`default_nettype none
module lbhcs_sync #(
  parameter int STAGES = 2
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic [STAGES-1:0] chain;
  logic [STAGES-1:0] next_chain;

  // shift toward the last stage, only the last is read
  always_comb begin
    next_chain = {chain[STAGES-2:0], async_in};
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chain <= '0;
    end else begin
      chain <= next_chain;
    end
  end

  assign sync_out = chain[STAGES-1];

endmodule
`default_nettype wire

//--- verilog/lbhcs_top.sv
// local bus hold handshake, chip select decode and transceiver control
`timescale 1ns/100ps
`default_nettype none
module lbhcs_top #(
  parameter int SYNC_STAGES = lbhcs_pkg::SYNC_STAGES
) (
  input  wire logic                            mclk,
  input  wire logic                            resetn,
  input  wire logic                            bus_request,
  output var  logic                            bus_grant_out,
  input  wire logic                            cyc_valid,
  output var  logic                            cyc_ready,
  input  wire lbhcs_pkg::lbhcs_req_t           cyc_req,
  output var  logic                            cyc_done,
  output var  logic [lbhcs_pkg::DATA_W-1:0]    cyc_rdata,
  input  wire lbhcs_pkg::lbhcs_cfg_t           cfg,
  output var  logic [lbhcs_pkg::ADDR_W-1:8]    lbus_addr_hi,
  output var  logic [lbhcs_pkg::DATA_W-1:0]    lbus_ad_out,
  input  wire logic [lbhcs_pkg::DATA_W-1:0]    lbus_ad_in,
  output var  logic                            lbus_addr_oe,
  output var  logic                            lbus_ad_oe,
  output var  logic                            lbus_ale,
  output var  logic                            lbus_read_n,
  output var  logic                            lbus_write_n,
  output var  logic                            lbus_ctrl_oe,
  output var  logic                            upper_mem_select_n,
  output var  logic                            lower_mem_select_n,
  output var  logic [lbhcs_pkg::N_MID-1:0]     midrange_mem_select_n,
  output var  logic [4:0]                      periph_select_n,
  output var  logic                            periph_sel5_or_latched_addr1,
  output var  logic                            periph_sel6_or_latched_addr2,
  output var  logic                            xcvr_direction,
  output var  logic                            xcvr_enable_n,
  output var  logic                            xcvr_enable_oe
);

  lbhcs_pkg::lbhcs_state_t st;
  lbhcs_pkg::lbhcs_state_t next_st;
  lbhcs_pkg::lbhcs_req_t   cur;
  lbhcs_pkg::lbhcs_req_t   next_cur;
  lbhcs_pkg::lbhcs_sel_t   sel;
  lbhcs_pkg::lbhcs_sel_t   next_sel;
  logic                    hold_s;
  logic                    drive;
  logic                    next_drive;
  logic                    rst_pulse;
  logic                    lat_a1;
  logic                    lat_a2;
  logic                    next_lat_a1;
  logic                    next_lat_a2;
  logic                    next_grant;
  logic                    next_dir;
  logic                    next_en_n;
  logic                    next_ale;
  logic                    next_rd_n;
  logic                    next_wr_n;
  logic [lbhcs_pkg::DATA_W-1:0] next_rdata;
  logic [lbhcs_pkg::DATA_W-1:0] next_ad;
  logic                    next_ad_oe;
  logic                    accept;
  logic                    next_in_cyc;

  // true for the four states of a running bus cycle
  function automatic logic in_cycle(input lbhcs_pkg::lbhcs_state_t s);
    return (s == lbhcs_pkg::ST_T1) || (s == lbhcs_pkg::ST_T2) ||
           (s == lbhcs_pkg::ST_T3) || (s == lbhcs_pkg::ST_T4);
  endfunction

  // address decode into active-high selects
  function automatic lbhcs_pkg::lbhcs_sel_t decode(input lbhcs_pkg::lbhcs_req_t r,
                                                   input lbhcs_pkg::lbhcs_cfg_t c);
    lbhcs_pkg::lbhcs_sel_t    d;
    logic [lbhcs_pkg::MID_W-1:0] msk;
    logic [4:0]               shamt;
    logic [1:0]               qidx;
    logic                     p_space;
    logic [2:0]               pidx;
    d       = '0;
    msk     = ~({lbhcs_pkg::MID_W{1'b1}} << c.mid_size_log);
    shamt   = lbhcs_pkg::MID_IDX_BASE + 5'(c.mid_size_log);
    qidx    = 2'(r.addr >> shamt);
    p_space = c.periph_in_io ? !r.is_mem : r.is_mem;
    pidx    = r.addr[lbhcs_pkg::PIDX_MSB:lbhcs_pkg::PIDX_LSB];
    d.upper = r.is_mem && (r.addr[lbhcs_pkg::ADDR_W-1:lbhcs_pkg::KB_LSB] >= c.upper_base);
    d.lower = r.is_mem && (r.addr[lbhcs_pkg::ADDR_W-1:lbhcs_pkg::KB_LSB] < c.lower_top);
    if (r.is_mem && ((r.addr[lbhcs_pkg::ADDR_W-1:lbhcs_pkg::MID_LSB] & ~msk) ==
                     (c.mid_base & ~msk))) begin
      d.mid[qidx] = 1'b1;
    end
    if (p_space && (r.addr[lbhcs_pkg::ADDR_W-1:lbhcs_pkg::KB_LSB] == c.periph_base)) begin
      for (int i = 0; i < lbhcs_pkg::N_PERIPH; i++) begin
        if (pidx == 3'(i)) begin
          d.periph[i] = 1'b1;
        end
      end
    end
    return d;
  endfunction

  lbhcs_sync #(
    .STAGES   (SYNC_STAGES)
  ) u_req_sync (
    .mclk     (mclk),
    .resetn   (resetn),
    .async_in (bus_request),
    .sync_out (hold_s)
  );

  // core may hand over a cycle in idle or the final state when no hold waits
  assign cyc_ready = ((st == lbhcs_pkg::ST_IDLE) || (st == lbhcs_pkg::ST_T4)) && !hold_s;
  assign accept    = cyc_ready && cyc_valid;
  assign cyc_done  = (st == lbhcs_pkg::ST_T4);

  // bus state sequencing and hold handshake
  always_comb begin
    next_st  = st;
    next_cur = cur;
    case (st)
      lbhcs_pkg::ST_IDLE,
      lbhcs_pkg::ST_T4: begin
        // hold is only entered from idle or the final state
        if (hold_s) begin
          next_st = lbhcs_pkg::ST_HOLD;
        end else if (accept) begin
          next_st  = lbhcs_pkg::ST_T1;
          next_cur = cyc_req;
        end else begin
          next_st = lbhcs_pkg::ST_IDLE;
        end
      end
      lbhcs_pkg::ST_T1: next_st = lbhcs_pkg::ST_T2;
      lbhcs_pkg::ST_T2: next_st = lbhcs_pkg::ST_T3;
      lbhcs_pkg::ST_T3: next_st = lbhcs_pkg::ST_T4;
      lbhcs_pkg::ST_HOLD: begin
        // release once the request is seen low
        if (!hold_s) begin
          next_st = lbhcs_pkg::ST_IDLE;
        end
      end
      default: next_st = lbhcs_pkg::ST_IDLE;
    endcase
  end

  // registered pin values derived from the next state
  always_comb begin
    next_in_cyc = in_cycle(next_st);
    next_grant  = (next_st == lbhcs_pkg::ST_HOLD);
    // drive again from the next own T1
    if (next_grant) begin
      next_drive = 1'b0;
    end else if (next_st == lbhcs_pkg::ST_T1) begin
      next_drive = 1'b1;
    end else begin
      next_drive = drive;
    end
    // selects only inside a running cycle
    next_sel    = next_in_cyc ? decode(next_cur, cfg) : '0;
    // address bits latched at the start of each cycle, kept otherwise
    next_lat_a1 = (next_st == lbhcs_pkg::ST_T1) ? next_cur.addr[lbhcs_pkg::LAT_A1_BIT] : lat_a1;
    next_lat_a2 = (next_st == lbhcs_pkg::ST_T1) ? next_cur.addr[lbhcs_pkg::LAT_A2_BIT] : lat_a2;
    // high only while a write cycle runs
    next_dir    = next_in_cyc && next_cur.is_write;
    // enable only in the data states, so the direction moves while it is high
    next_en_n   = !((next_st == lbhcs_pkg::ST_T2) || (next_st == lbhcs_pkg::ST_T3));
    next_ale    = (next_st == lbhcs_pkg::ST_T1);
    next_rd_n   = !(!next_en_n && !next_cur.is_write);
    next_wr_n   = !(!next_en_n && next_cur.is_write);
    if (next_st == lbhcs_pkg::ST_T1) begin
      next_ad    = next_cur.addr[lbhcs_pkg::DATA_W-1:0];
      next_ad_oe = next_drive;
    end else if (next_in_cyc && next_cur.is_write) begin
      next_ad    = next_cur.wdata;
      next_ad_oe = next_drive;
    end else begin
      next_ad    = '0;
      next_ad_oe = 1'b0;
    end
    next_rdata  = (st == lbhcs_pkg::ST_T3 && !cur.is_write) ? lbus_ad_in : cyc_rdata;
  end

  // state and pin registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st             <= lbhcs_pkg::ST_IDLE;
      cur            <= '0;
      sel            <= '0;
      drive          <= 1'b0;
      rst_pulse      <= 1'b1;
      lat_a1         <= 1'b0;
      lat_a2         <= 1'b0;
      bus_grant_out  <= 1'b0;
      xcvr_direction <= 1'b0;
      xcvr_enable_n  <= lbhcs_pkg::XCVR_EN_RST;
      lbus_ale       <= 1'b0;
      lbus_read_n    <= 1'b1;
      lbus_write_n   <= 1'b1;
      lbus_ad_out    <= '0;
      lbus_ad_oe     <= 1'b0;
      cyc_rdata      <= '0;
    end else begin
      st             <= next_st;
      cur            <= next_cur;
      sel            <= next_sel;
      drive          <= next_drive;
      rst_pulse      <= 1'b0;
      lat_a1         <= next_lat_a1;
      lat_a2         <= next_lat_a2;
      bus_grant_out  <= next_grant;
      xcvr_direction <= next_dir;
      xcvr_enable_n  <= next_en_n;
      lbus_ale       <= next_ale;
      lbus_read_n    <= next_rd_n;
      lbus_write_n   <= next_wr_n;
      lbus_ad_out    <= next_ad;
      lbus_ad_oe     <= next_ad_oe;
      cyc_rdata      <= next_rdata;
    end
  end

  // address and control float with the drive flag
  assign lbus_addr_hi = cur.addr[lbhcs_pkg::ADDR_W-1:8];
  assign lbus_addr_oe = drive;
  assign lbus_ctrl_oe = drive;

  // selects have no enable and are always driven
  assign upper_mem_select_n    = !sel.upper;
  assign lower_mem_select_n    = !sel.lower;
  assign midrange_mem_select_n = ~sel.mid;
  assign periph_select_n       = ~sel.periph[4:0];

  // two pins shared between selects and latched address
  // latched value is held through a hold
  assign periph_sel5_or_latched_addr1 = cfg.latch_addr_mode ? lat_a1 : !sel.periph[5];
  assign periph_sel6_or_latched_addr2 = cfg.latch_addr_mode ? lat_a2 : !sel.periph[6];

  // one driven clock after reset, then floated until the first own cycle and during a hold
  assign xcvr_enable_oe = rst_pulse || drive;

  sequence s_cycle_walk;
    st == lbhcs_pkg::ST_T2 ##1 st == lbhcs_pkg::ST_T3 ##1 st == lbhcs_pkg::ST_T4;
  endsequence

  sequence s_final_or_idle;
    (st == lbhcs_pkg::ST_T4) || (st == lbhcs_pkg::ST_IDLE);
  endsequence

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_grant_at_boundary: assert property ($rose(bus_grant_out) |-> ($past(st) == lbhcs_pkg::ST_T4) || ($past(st) == lbhcs_pkg::ST_IDLE)) else $error("grant inside a cycle");
  a_float_with_grant: assert property (bus_grant_out |-> !lbus_ad_oe && !lbus_ctrl_oe && !lbus_addr_oe) else $error("bus driven while granted");
  a_grant_release: assert property (st == lbhcs_pkg::ST_HOLD && !hold_s |=> !bus_grant_out) else $error("grant held after release");
  a_cycle_drives: assert property (st == lbhcs_pkg::ST_T1 |-> lbus_ctrl_oe && lbus_ad_oe ##0 (##1 s_cycle_walk)) else $error("own cycle not driven");
  a_sync_latency: assert property (s_final_or_idle ##0 $rose(hold_s) |=> bus_grant_out) else $error("hold not granted");
  a_select_idle: assert property (!in_cycle(st) |-> upper_mem_select_n && lower_mem_select_n && (&midrange_mem_select_n) && (&periph_select_n)) else $error("select active outside cycle");
  a_latched_hold: assert property (cfg.latch_addr_mode && $stable(cfg.latch_addr_mode) && st == lbhcs_pkg::ST_HOLD && $past(st) == lbhcs_pkg::ST_HOLD |-> $stable(periph_sel5_or_latched_addr1) && $stable(periph_sel6_or_latched_addr2)) else $error("latched address moved in hold");
  a_dir_enable: assert property ($changed(xcvr_direction) |-> xcvr_enable_n) else $error("direction changed while enabled");
  a_dir_write: assert property (st == lbhcs_pkg::ST_T3 |-> xcvr_direction == cur.is_write && !xcvr_enable_n) else $error("direction wrong in data phase");
  a_enable_float: assert property (bus_grant_out |-> !xcvr_enable_oe) else $error("enable driven in hold");

endmodule
`default_nettype wire

//--- sim/lbhcs_other_master.sv
// model of the other bus master that borrows the local bus
`timescale 1ns/100ps
`default_nettype none
module lbhcs_other_master #(
  parameter real SKEW = 2.3
) (
  input  wire logic want_bus,
  output var  logic bus_request
);
  // request follows the wish to own the bus, off the clock grid
  // async request, held while needed
  initial begin
    bus_request = 1'b0;
    forever begin
      @(want_bus);
      bus_request <= #(SKEW) want_bus;
    end
  end
endmodule
`default_nettype wire

//--- sim/tb_local_bus_hold_and_chip_select.sv
// self-checking bench for the local bus hold and chip select block
`timescale 1ns/100ps
`default_nettype none
`define CHK(act, exp, msg) begin \
  tests_run++; \
  if ((act) !== (exp)) begin \
    mismatches++; \
    $display("CHECK FAILED t=%0t %s", $time, msg); \
  end \
end
module tb_local_bus_hold_and_chip_select;
  logic                   mclk;
  logic                   resetn;
  logic                   want;
  logic                   valid;
  logic [7:0]             ad_in;
  lbhcs_pkg::lbhcs_req_t  req;
  lbhcs_pkg::lbhcs_cfg_t  cfg;
  wire logic              bus_request;
  wire logic              bus_grant_out;
  wire logic              cyc_ready;
  wire logic              cyc_done;
  wire logic [7:0]        cyc_rdata;
  wire logic [19:8]       lbus_addr_hi;
  wire logic [7:0]        lbus_ad_out;
  wire logic              lbus_addr_oe;
  wire logic              lbus_ad_oe;
  wire logic              lbus_ale;
  wire logic              lbus_read_n;
  wire logic              lbus_write_n;
  wire logic              lbus_ctrl_oe;
  wire logic              upper_mem_select_n;
  wire logic              lower_mem_select_n;
  wire logic [3:0]        midrange_mem_select_n;
  wire logic [4:0]        periph_select_n;
  wire logic              periph_sel5_or_latched_addr1;
  wire logic              periph_sel6_or_latched_addr2;
  wire logic              xcvr_direction;
  wire logic              xcvr_enable_n;
  wire logic              xcvr_enable_oe;
  wire logic [12:0]       sel_n;
  int                     mismatches = 0;
  int                     tests_run = 0;
  logic                   p_gnt = 1'b0;
  logic                   p_dir = 1'b0;
  logic                   p_busy = 1'b0;

  // all select pins as one vector, upper first
  assign sel_n = {upper_mem_select_n, lower_mem_select_n, midrange_mem_select_n,
                  periph_sel6_or_latched_addr2, periph_sel5_or_latched_addr1, periph_select_n};

  lbhcs_top dut_u (.mclk(mclk), .resetn(resetn), .bus_request(bus_request),
    .bus_grant_out(bus_grant_out), .cyc_valid(valid), .cyc_ready(cyc_ready), .cyc_req(req),
    .cyc_done(cyc_done), .cyc_rdata(cyc_rdata), .cfg(cfg), .lbus_addr_hi(lbus_addr_hi),
    .lbus_ad_out(lbus_ad_out), .lbus_ad_in(ad_in), .lbus_addr_oe(lbus_addr_oe),
    .lbus_ad_oe(lbus_ad_oe), .lbus_ale(lbus_ale), .lbus_read_n(lbus_read_n),
    .lbus_write_n(lbus_write_n), .lbus_ctrl_oe(lbus_ctrl_oe),
    .upper_mem_select_n(upper_mem_select_n), .lower_mem_select_n(lower_mem_select_n),
    .midrange_mem_select_n(midrange_mem_select_n), .periph_select_n(periph_select_n),
    .periph_sel5_or_latched_addr1(periph_sel5_or_latched_addr1),
    .periph_sel6_or_latched_addr2(periph_sel6_or_latched_addr2),
    .xcvr_direction(xcvr_direction), .xcvr_enable_n(xcvr_enable_n),
    .xcvr_enable_oe(xcvr_enable_oe));

  lbhcs_other_master other_u (.want_bus(want), .bus_request(bus_request));

  // clock at 125 MHz
  always #4 mclk = ~mclk;

  // grant rises and direction turns watched on every cycle
  always @(negedge mclk) begin
    if (resetn && bus_grant_out && !p_gnt)
      `CHK(p_busy, 1'b0, "grant inside a cycle")
    if (resetn && xcvr_direction !== p_dir)
      `CHK(xcvr_enable_n, 1'b1, "enable low at turn")
    p_gnt = bus_grant_out;
    p_dir = xcvr_direction;
    p_busy = lbus_ale | (xcvr_enable_oe & ~xcvr_enable_n);
  end

  // one core bus cycle, judged state by state
  task automatic cyc(input logic mem, input logic wr, input logic [19:0] a,
                     input logic [7:0] d, input logic [12:0] esel);
    int n;
    logic [12:0] eidle;
    n = 0;
    eidle = cfg.latch_addr_mode ? (13'h1F9F | esel) : 13'h1FFF;
    @(posedge mclk);
    #1 req = '{is_mem: mem, is_write: wr, addr: a, wdata: d};
    ad_in = d;
    valid = 1'b1;
    do begin
      @(negedge mclk);
      n++;
    end while (cyc_ready !== 1'b1 && n < 50);
    `CHK(n < 50, 1'b1, "cycle not taken")
    @(posedge mclk);
    #1 valid = 1'b0;
    @(negedge mclk);
    `CHK(sel_n, esel, "select decode")
    `CHK({lbus_ale, lbus_ctrl_oe, xcvr_enable_oe, xcvr_enable_n, xcvr_direction}, {4'hF, wr},
         "first state controls")
    `CHK({lbus_addr_oe, lbus_ad_oe, lbus_addr_hi, lbus_ad_out}, {2'b11, a}, "address out")
    @(negedge mclk);
    `CHK({xcvr_enable_n, lbus_read_n, lbus_write_n}, {1'b0, wr, ~wr}, "strobes")
    `CHK({lbus_ad_oe, lbus_ad_out}, {wr, wr ? d : 8'h00}, "data phase")
    repeat (2) @(negedge mclk);
    `CHK({cyc_done, xcvr_enable_n, xcvr_direction}, {2'b11, wr}, "final state")
    @(negedge mclk);
    `CHK({sel_n, xcvr_direction}, {eidle, 1'b0}, "selects idle")
    if (!wr)
      `CHK(cyc_rdata, d, "read data")
  endtask

  // each select but mid 0 and 2 and peripheral 3, and the misses, memory and I/O
  task automatic decode_all();
    cyc(1'b1, 1'b0, 20'hFC010, 8'hA1, 13'h0FFF);
    cyc(1'b1, 1'b1, 20'h00100, 8'hB2, 13'h17FF);
    cyc(1'b1, 1'b0, 20'h22000, 8'hC3, 13'h1EFF);
    cyc(1'b1, 1'b1, 20'h26000, 8'hD4, 13'h1BFF);
    cyc(1'b0, 1'b1, 20'h01000, 8'hE5, 13'h1FFE);
    cyc(1'b0, 1'b0, 20'h01080, 8'hF6, 13'h1FFD);
    cyc(1'b0, 1'b0, 20'h01200, 8'h07, 13'h1FEF);
    cyc(1'b0, 1'b0, 20'h01280, 8'h18, 13'h1FDF);
    cyc(1'b0, 1'b1, 20'h01300, 8'h29, 13'h1FBF);
    cyc(1'b0, 1'b0, 20'h01380, 8'h3A, 13'h1FFF);
    cyc(1'b0, 1'b0, 20'hFC010, 8'h4B, 13'h1FFF);
    cyc(1'b1, 1'b0, 20'h01080, 8'h5C, 13'h17FF);
    cyc(1'b1, 1'b0, 20'h80000, 8'h6D, 13'h1FFF);
    @(posedge mclk);
    #1 cfg.periph_in_io = 1'b0;
    cyc(1'b1, 1'b0, 20'h01100, 8'h7E, 13'h17FB);
    cyc(1'b0, 1'b0, 20'h01100, 8'h8F, 13'h1FFF);
    @(posedge mclk);
    #1 cfg.periph_in_io = 1'b1;
    $display("test decode_all done");
  endtask

  // other master takes an idle bus and gives it back
  task automatic hold_idle(input logic [12:0] ehold);
    int n;
    n = 0;
    want = 1'b1;
    while (bus_grant_out !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    `CHK(n inside {[3:5]}, 1'b1, "grant latency")
    `CHK({lbus_addr_oe, lbus_ad_oe, lbus_ctrl_oe, xcvr_enable_oe}, 4'h0, "bus floated")
    repeat (6) @(negedge mclk);
    `CHK({bus_grant_out, cyc_ready, sel_n}, {2'b10, ehold}, "hold state")
    want = 1'b0;
    n = 0;
    while (bus_grant_out !== 1'b0 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    `CHK(n inside {[3:5]}, 1'b1, "grant release")
    repeat (3) @(negedge mclk);
    `CHK({lbus_ctrl_oe, xcvr_enable_oe, sel_n}, {2'b00, ehold}, "floated until cycle")
    $display("test hold_idle done");
  endtask

  // request arrives mid-cycle, then a core cycle waits out the hold
  task automatic hold_in_cycle();
    fork
      cyc(1'b1, 1'b0, 20'hFC020, 8'h3C, 13'h0FFF);
      begin
        repeat (2) @(negedge mclk);
        want = 1'b1;
      end
    join
    `CHK(bus_grant_out, 1'b1, "grant after final state")
    fork
      cyc(1'b0, 1'b1, 20'h01080, 8'h5A, 13'h1FFD);
      begin
        repeat (4) @(negedge mclk);
        `CHK({bus_grant_out, cyc_ready}, 2'b10, "cycle held off")
        want = 1'b0;
      end
    join
    $display("test hold_in_cycle done");
  endtask

  // latched address bits through a hold
  task automatic latched_addr();
    @(posedge mclk);
    #1 cfg.latch_addr_mode = 1'b1;
    cyc(1'b1, 1'b0, 20'h80004, 8'h11, 13'h1FDF);
    hold_idle(13'h1FDF);
    cyc(1'b1, 1'b1, 20'h80002, 8'h22, 13'h1FBF);
    $display("test latched_addr done");
  endtask

  // counts, verdict and end of run
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    want = 1'b0;
    valid = 1'b0;
    ad_in = 8'h00;
    req = '0;
    cfg = '{upper_base: 10'h3F0, lower_top: 10'h010, mid_base: 7'h10, mid_size_log: 3'h2,
            periph_base: 10'h004, periph_in_io: 1'b1, latch_addr_mode: 1'b0};
    repeat (10) @(posedge mclk);
    `CHK({xcvr_enable_oe, xcvr_enable_n, bus_grant_out, sel_n}, {3'b110, 13'h1FFF},
         "in reset")
    #1 resetn = 1'b1;
    @(negedge mclk);
    `CHK(xcvr_enable_oe, 1'b1, "enable driven one clock")
    @(negedge mclk);
    `CHK(xcvr_enable_oe, 1'b0, "enable floated")
    decode_all();
    hold_idle(13'h1FFF);
    hold_in_cycle();
    latched_addr();
    end_sim();
  end

  // watchdog against a hung handshake
  initial begin
    #(3000 * 8);
    mismatches++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
